// >>> inc/pir_pkg.sv
package pir_pkg;

  // Register byte addresses on the bus
  localparam logic [7:0] OFF_EN4 = 8'h00;
  localparam logic [7:0] OFF_REQ1 = 8'h04;
  localparam logic [7:0] OFF_EN1 = 8'h08;
  localparam logic [7:0] OFF_CORE = 8'h0C;
  localparam logic [7:0] OFF_EVT_STS = 8'h10;
  localparam logic [7:0] OFF_EVT_CLR = 8'h14;
  localparam logic [7:0] OFF_EVT_EN = 8'h18;

  // Request flag positions
  localparam int BIT_T1_GATE = 7;
  localparam int BIT_ADC = 6;
  localparam int BIT_UART_RX = 5;
  localparam int BIT_UART_TX = 4;
  localparam int BIT_SER1 = 3;
  localparam int BIT_CAPCOMP1 = 2;
  localparam int BIT_T2_MATCH = 1;
  localparam int BIT_T1_OVF = 0;

  // Second enable register positions
  localparam int BIT_SER2_COLL = 1;
  localparam int BIT_SER2_XFER = 0;

  // Core control positions
  localparam int BIT_GLOBAL = 7;
  localparam int BIT_GATE = 6;

  // Software-writable flags; the two UART flags are excluded
  localparam logic [7:0] REQ1_RW_MASK = 8'hCF;

  // Reset values
  localparam logic [7:0] RST_REQ1 = 8'h00;
  localparam logic [7:0] RST_EN1 = 8'h00;
  localparam logic [1:0] RST_EN4 = 2'h0;
  localparam logic [7:0] RST_EVT = 8'h00;

  typedef struct packed {
    logic timer1_gate;
    logic adc_done;
    logic serial1_transfer;
    logic capcomp1;
    logic timer1_overflow;
  } pir_events_t;

  typedef struct packed {
    logic rx;
    logic tx;
  } pir_uart_t;

  typedef struct packed {
    logic [1:0] en4;
    logic [7:0] req1;
    logic [7:0] en1;
    logic gate;
    logic glob;
    logic [7:0] evt_sts;
    logic [7:0] evt_en;
    logic ack;
    logic [31:0] rdat;
    logic cpu_irq;
    logic evt_irq;
  } pir_state_t;

  typedef struct packed {
    logic eq;
    logic hit;
  } pir_match_t;

  typedef struct packed {
    logic meta;
    logic sync;
  } pir_sync_t;

endpackage : pir_pkg

// >>> design/pir_rst_sync.sv
`timescale 1ns/10ps
module pir_rst_sync (
  // Clock and raw reset
  input wire logic clk,
  input wire logic rst_n,
  // Released reset
  output logic rst_sync_n
);

  pir_pkg::pir_sync_t st_q;
  pir_pkg::pir_sync_t st_d;

  always_comb begin
    st_d.meta = 1'b1;
    st_d.sync = st_q.meta;
  end

  // Assert at once, release only after two clean edges
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign rst_sync_n = st_q.sync;

endmodule : pir_rst_sync

// >>> design/pir_match.sv
`timescale 1ns/10ps
module pir_match #(
  parameter int W = 8
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Timer count and period
  input wire logic [W-1:0] count,
  input wire logic [W-1:0] period,
  // One pulse per new match
  output logic hit
);

  pir_pkg::pir_match_t st_q;
  pir_pkg::pir_match_t st_d;

  // A count parked on the period must not flood the flag with pulses
  always_comb begin
    st_d.eq = (count == period);
    st_d.hit = (count == period) && !st_q.eq;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign hit = st_q.hit;

endmodule : pir_match

// >>> design/pir_regs.sv
// The register offsets and register access over Wishbone were left to the implementer.
`timescale 1ns/10ps
module pir_regs #(
  parameter bit HAS_EN4 = 1'b1,
  parameter int T2_W = 8
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Wishbone classic slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Peripheral events
  input wire pir_pkg::pir_events_t evt_i,
  input wire pir_pkg::pir_uart_t uart_i,
  input wire logic [T2_W-1:0] timer2_count,
  input wire logic [T2_W-1:0] timer2_period_reg,
  input wire logic [1:0] serial2_flags,
  // Interrupt outputs
  output logic cpu_irq,
  output logic evt_irq
);

  pir_pkg::pir_state_t st_q;
  pir_pkg::pir_state_t st_d;
  logic rst_s_n;
  logic t2_hit;
  logic req;
  logic wr;
  logic [7:0] set_v;
  logic [7:0] wbyte;

  function automatic logic is_at(input logic [7:0] adr,
                                 input logic [7:0] off);
    is_at = (adr == off);
  endfunction : is_at

  pir_rst_sync u_rst (
    .clk(clk),
    .rst_n(rst_n),
    .rst_sync_n(rst_s_n)
  );

  pir_match #(.W(T2_W)) u_t2 (
    .clk(clk),
    .rst_n(rst_s_n),
    .count(timer2_count),
    .period(timer2_period_reg),
    .hit(t2_hit)
  );

  // One access per request: ack in the cycle after stb, then dropped
  assign req = wb_cyc_i && wb_stb_i && !st_q.ack;
  assign wr = req && wb_we_i && wb_sel_i[0];
  assign wbyte = wb_dat_i[7:0];

  // Event vector in flag order; UART events are their rising levels
  always_comb begin
    set_v = 8'h00;
    set_v[pir_pkg::BIT_T1_GATE] = evt_i.timer1_gate;
    set_v[pir_pkg::BIT_ADC] = evt_i.adc_done;
    set_v[pir_pkg::BIT_UART_RX] =
      uart_i.rx && !st_q.req1[pir_pkg::BIT_UART_RX];
    set_v[pir_pkg::BIT_UART_TX] =
      uart_i.tx && !st_q.req1[pir_pkg::BIT_UART_TX];
    set_v[pir_pkg::BIT_SER1] = evt_i.serial1_transfer;
    set_v[pir_pkg::BIT_CAPCOMP1] = evt_i.capcomp1;
    set_v[pir_pkg::BIT_T2_MATCH] = t2_hit;
    set_v[pir_pkg::BIT_T1_OVF] = evt_i.timer1_overflow;
  end

  always_comb begin
    st_d = st_q;
    st_d.ack = req;

    // Second enable register, absent on the small variant
    if (wr && is_at(wb_adr_i, pir_pkg::OFF_EN4) && HAS_EN4) begin
      st_d.en4 = wbyte[1:0];
    end
    if (wr && is_at(wb_adr_i, pir_pkg::OFF_EN1)) begin
      st_d.en1 = wbyte;
    end
    if (wr && is_at(wb_adr_i, pir_pkg::OFF_CORE)) begin
      st_d.glob = wbyte[pir_pkg::BIT_GLOBAL];
      st_d.gate = wbyte[pir_pkg::BIT_GATE];
    end

    // Writable flags take the written value, then events win over it
    if (wr && is_at(wb_adr_i, pir_pkg::OFF_REQ1)) begin
      st_d.req1 = wbyte & pir_pkg::REQ1_RW_MASK;
    end
    st_d.req1 = st_d.req1 | (set_v & pir_pkg::REQ1_RW_MASK);
    // UART flags mirror the receiver and transmitter state only
    st_d.req1[pir_pkg::BIT_UART_RX] = uart_i.rx;
    st_d.req1[pir_pkg::BIT_UART_TX] = uart_i.tx;

    // Sticky event log; a new event beats a clear in the same cycle
    if (wr && is_at(wb_adr_i, pir_pkg::OFF_EVT_CLR)) begin
      st_d.evt_sts = st_q.evt_sts & ~wbyte;
    end
    st_d.evt_sts = st_d.evt_sts | set_v;
    if (wr && is_at(wb_adr_i, pir_pkg::OFF_EVT_EN)) begin
      st_d.evt_en = wbyte;
    end
    st_d.evt_irq = |(st_q.evt_sts & st_q.evt_en);

    // Processor request, gated by both core bits
    st_d.cpu_irq = st_q.glob && st_q.gate &&
      ((|(st_q.req1 & st_q.en1)) ||
       (|(serial2_flags & st_q.en4)));

    // Read data; unmapped and write-only addresses answer zero
    st_d.rdat = 32'h0000_0000;
    if (req && !wb_we_i) begin
      if (is_at(wb_adr_i, pir_pkg::OFF_EN4)) begin
        st_d.rdat[1:0] = st_q.en4;
      end else if (is_at(wb_adr_i, pir_pkg::OFF_REQ1)) begin
        st_d.rdat[7:0] = st_q.req1;
      end else if (is_at(wb_adr_i, pir_pkg::OFF_EN1)) begin
        st_d.rdat[7:0] = st_q.en1;
      end else if (is_at(wb_adr_i, pir_pkg::OFF_CORE)) begin
        st_d.rdat[pir_pkg::BIT_GLOBAL] = st_q.glob;
        st_d.rdat[pir_pkg::BIT_GATE] = st_q.gate;
      end else if (is_at(wb_adr_i, pir_pkg::OFF_EVT_STS)) begin
        st_d.rdat[7:0] = st_q.evt_sts;
      end else if (is_at(wb_adr_i, pir_pkg::OFF_EVT_EN)) begin
        st_d.rdat[7:0] = st_q.evt_en;
      end
    end
  end

  // Every reset source lands here through the synchroniser
  always_ff @(posedge clk or negedge rst_s_n) begin
    if (!rst_s_n) begin
      st_q <= '0;
      st_q.req1 <= pir_pkg::RST_REQ1;
      st_q.en1 <= pir_pkg::RST_EN1;
      st_q.en4 <= pir_pkg::RST_EN4;
      st_q.evt_sts <= pir_pkg::RST_EVT;
      st_q.evt_en <= pir_pkg::RST_EVT;
    end else begin
      st_q <= st_d;
    end
  end

  assign wb_dat_o = st_q.rdat;
  assign wb_ack_o = st_q.ack;
  assign cpu_irq = st_q.cpu_irq;
  assign evt_irq = st_q.evt_irq;

  AST_GATE_BLOCKS: assert property (
    @(posedge clk) disable iff (!rst_s_n)
    !st_q.gate |=> !cpu_irq)
    else $error("request passed with peripheral gate clear");

  AST_EN4_UPPER_ZERO: assert property (
    @(posedge clk) disable iff (!rst_s_n)
    (req && !wb_we_i && is_at(wb_adr_i, pir_pkg::OFF_EN4))
      |=> (wb_ack_o && wb_dat_o[31:2] == 30'h0000_0000))
    else $error("upper enable bits read nonzero");

  AST_EN4_WRITE: assert property (
    @(posedge clk) disable iff (!rst_s_n)
    (wr && is_at(wb_adr_i, pir_pkg::OFF_EN4))
      |=> st_q.en4 == (HAS_EN4 ? $past(wbyte[1:0]) : 2'h0))
    else $error("second enable register write mismatch");

  AST_SER2_ENABLE: assert property (
    @(posedge clk) disable iff (!rst_s_n)
    (st_q.glob && st_q.gate && st_q.en1 == 8'h00 &&
     (serial2_flags & st_q.en4) == 2'h0) |=> !cpu_irq)
    else $error("serial2 request without its enable");

  AST_FLAG_SETS: assert property (
    @(posedge clk) disable iff (!rst_s_n)
    evt_i.timer1_overflow |=> st_q.req1[pir_pkg::BIT_T1_OVF])
    else $error("overflow event lost");

  AST_UART_MIRROR: assert property (
    @(posedge clk) disable iff (!rst_s_n)
    1'b1 |=> st_q.req1[pir_pkg::BIT_UART_RX] == $past(uart_i.rx) &&
             st_q.req1[pir_pkg::BIT_UART_TX] == $past(uart_i.tx))
    else $error("uart flag changed by something other than uart");

  AST_SW_WRITE: assert property (
    @(posedge clk) disable iff (!rst_s_n)
    (wr && is_at(wb_adr_i, pir_pkg::OFF_REQ1) &&
     !evt_i.timer1_gate)
      |=> st_q.req1[pir_pkg::BIT_T1_GATE] == $past(wbyte[7]))
    else $error("writable flag did not take written value");

  AST_T2_MATCH: assert property (
    @(posedge clk) disable iff (!rst_s_n)
    $rose(timer2_count == timer2_period_reg)
      |-> ##2 st_q.req1[pir_pkg::BIT_T2_MATCH])
    else $error("timer2 match did not set its flag");

  AST_REQ_RAISE: assert property (
    @(posedge clk) disable iff (!rst_s_n)
    (st_q.glob && st_q.gate && |(st_q.req1 & st_q.en1)) |=> cpu_irq)
    else $error("enabled pending flag raised no request");

  AST_ACK_ONE: assert property (
    @(posedge clk) disable iff (!rst_s_n)
    wb_ack_o |=> !wb_ack_o)
    else $error("ack held for more than one cycle");

  // Checked while reset is low, so no disable clause here
  AST_RESET_CLEAR: assert property (
    @(posedge clk)
    !rst_s_n |-> (st_q.req1 == 8'h00 && st_q.en1 == 8'h00 &&
                  st_q.en4 == 2'h0 && !cpu_irq && !wb_ack_o))
    else $error("state not cleared while in reset");

  AST_EN1_WRITE: assert property (
    @(posedge clk) disable iff (!rst_s_n)
    (wr && is_at(wb_adr_i, pir_pkg::OFF_EN1))
      |=> st_q.en1 == $past(wbyte))
    else $error("enable register write mismatch");

  AST_CORE_WRITE: assert property (
    @(posedge clk) disable iff (!rst_s_n)
    (wr && is_at(wb_adr_i, pir_pkg::OFF_CORE))
      |=> (st_q.gate == $past(wbyte[pir_pkg::BIT_GATE]) &&
           st_q.glob == $past(wbyte[pir_pkg::BIT_GLOBAL])))
    else $error("core control write mismatch");

  AST_GLOBAL_BLOCKS: assert property (
    @(posedge clk) disable iff (!rst_s_n)
    !st_q.glob |=> !cpu_irq)
    else $error("request passed with global enable clear");

  AST_SER2_COLL_RAISE: assert property (
    @(posedge clk) disable iff (!rst_s_n)
    (st_q.glob && st_q.gate && serial2_flags[1] && st_q.en4[1])
      |=> cpu_irq)
    else $error("enabled serial2 collision raised no request");

  AST_SER2_XFER_RAISE: assert property (
    @(posedge clk) disable iff (!rst_s_n)
    (st_q.glob && st_q.gate && serial2_flags[0] && st_q.en4[0])
      |=> cpu_irq)
    else $error("enabled serial2 transfer raised no request");

  AST_GATE_FLAG: assert property (
    @(posedge clk) disable iff (!rst_s_n)
    evt_i.timer1_gate |=> (st_q.req1[pir_pkg::BIT_T1_GATE] &&
                           st_q.evt_sts[pir_pkg::BIT_T1_GATE]))
    else $error("timer1 gate event lost");

  AST_ADC_FLAG: assert property (
    @(posedge clk) disable iff (!rst_s_n)
    evt_i.adc_done |=> (st_q.req1[pir_pkg::BIT_ADC] &&
                        st_q.evt_sts[pir_pkg::BIT_ADC]))
    else $error("converter event lost");

  AST_SER1_FLAG: assert property (
    @(posedge clk) disable iff (!rst_s_n)
    evt_i.serial1_transfer |=> st_q.req1[pir_pkg::BIT_SER1])
    else $error("serial1 event lost");

  AST_CAPCOMP_FLAG: assert property (
    @(posedge clk) disable iff (!rst_s_n)
    evt_i.capcomp1 |=> st_q.req1[pir_pkg::BIT_CAPCOMP1])
    else $error("capture compare event lost");

  AST_FLAG_HOLD: assert property (
    @(posedge clk) disable iff (!rst_s_n)
    (st_q.req1[pir_pkg::BIT_T1_OVF] &&
     !(wr && is_at(wb_adr_i, pir_pkg::OFF_REQ1)))
      |=> st_q.req1[pir_pkg::BIT_T1_OVF])
    else $error("pending flag dropped without a write");

  AST_EVT_STICKY: assert property (
    @(posedge clk) disable iff (!rst_s_n)
    (st_q.evt_sts[pir_pkg::BIT_ADC] &&
     !(wr && is_at(wb_adr_i, pir_pkg::OFF_EVT_CLR)))
      |=> st_q.evt_sts[pir_pkg::BIT_ADC])
    else $error("event status dropped without a clear");

  AST_REQ1_READ: assert property (
    @(posedge clk) disable iff (!rst_s_n)
    (req && !wb_we_i && is_at(wb_adr_i, pir_pkg::OFF_REQ1))
      |=> (wb_dat_o[7:0] == $past(st_q.req1) &&
           wb_dat_o[31:8] == 24'h00_0000))
    else $error("request register read mismatch");

  AST_UART_NOWRITE: assert property (
    @(posedge clk) disable iff (!rst_s_n)
    (wr && is_at(wb_adr_i, pir_pkg::OFF_REQ1))
      |=> (st_q.req1[pir_pkg::BIT_UART_RX] == $past(uart_i.rx) &&
           st_q.req1[pir_pkg::BIT_UART_TX] == $past(uart_i.tx)))
    else $error("software write reached a uart flag");

  // A parked count must give one pulse, not one per cycle
  AST_T2_ONE_PULSE: assert property (
    @(posedge clk) disable iff (!rst_s_n)
    t2_hit |=> !t2_hit)
    else $error("timer2 match pulse repeated");

  AST_ACK_ANSWER: assert property (
    @(posedge clk) disable iff (!rst_s_n)
    req |=> wb_ack_o)
    else $error("taken request not acknowledged");

  AST_DAT_IDLE: assert property (
    @(posedge clk) disable iff (!rst_s_n)
    !wb_ack_o |-> wb_dat_o == 32'h0000_0000)
    else $error("read data shown without ack");

  AST_EVT_IRQ_SET: assert property (
    @(posedge clk) disable iff (!rst_s_n)
    (|(st_q.evt_sts & st_q.evt_en)) |=> evt_irq)
    else $error("enabled event raised no event interrupt");

  AST_EVT_IRQ_CLR: assert property (
    @(posedge clk) disable iff (!rst_s_n)
    !(|(st_q.evt_sts & st_q.evt_en)) |=> !evt_irq)
    else $error("event interrupt without enabled status");

  // A write with its byte lane off is acked but must change nothing
  AST_SEL_IGNORED: assert property (
    @(posedge clk) disable iff (!rst_s_n)
    (req && wb_we_i && !wb_sel_i[0])
      |=> ($stable(st_q.en4) && $stable(st_q.en1)))
    else $error("write without byte lane changed a register");

endmodule : pir_regs

// >>> tb/pir_src_model.sv
`timescale 1ns/10ps
module pir_src_model #(
  parameter logic [7:0] PERIOD = 8'h05
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Bench commands
  input wire pir_pkg::pir_events_t fire,
  input wire logic t2_run,
  // Event lines toward the registers
  output pir_pkg::pir_events_t evt,
  output logic [7:0] t2_count,
  output logic [7:0] t2_period
);
  assign t2_period = PERIOD;
  // Events leave as single registered strobes, like real peripherals
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      evt <= '0;
      t2_count <= 8'h00;
    end else begin
      evt <= fire;
      if (t2_run) begin
        // Wrap after the match so each period makes one new match
        t2_count <= (t2_count == PERIOD) ? 8'h00 : t2_count + 8'h01;
      end
    end
  end
endmodule : pir_src_model

// >>> tb/pir_regs_tb.sv
`timescale 1ns/10ps
module pir_regs_tb;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0;
  logic [31:0] q;
  logic [31:0] dat_o;
  logic ack, cpu_irq, evt_irq, t2_run = 1'b0;
  logic [1:0] ser2 = 2'h0;
  logic [3:0] sel = 4'h1;
  pir_pkg::pir_events_t fire = '0;
  pir_pkg::pir_events_t evt;
  pir_pkg::pir_uart_t uart = '0;
  logic [7:0] t2c, t2p;
  int errors = 0;
  int tests_run = 0;

  always #25 clk = ~clk;

  pir_src_model i_pir_src_model (.clk(clk), .rst_n(rst_n), .fire(fire),
    .t2_run(t2_run), .evt(evt), .t2_count(t2c), .t2_period(t2p));
  pir_regs #(.HAS_EN4(1'b1), .T2_W(8)) i_pir_regs (.clk(clk),
    .rst_n(rst_n), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(dat_o),
    .wb_ack_o(ack), .evt_i(evt), .uart_i(uart), .timer2_count(t2c),
    .timer2_period_reg(t2p), .serial2_flags(ser2), .cpu_irq(cpu_irq),
    .evt_irq(evt_irq));

  task automatic test_done();
    if (errors == 0 && tests_run > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : test_done

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      errors++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // Request held until the edge that samples ack; data taken there
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 20);
    q = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    if (ack !== 1'b1) begin
      errors++;
      $display("ERROR wb_ack_o expected 1 seen %b", ack);
      test_done();
    end
  endtask : bus

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk($sformatf("reg %h", a), e, q);
  endtask : rd

  task automatic pulse(input pir_pkg::pir_events_t e);
    @(posedge clk);
    fire <= e;
    @(posedge clk);
    fire <= '0;
    repeat (3) @(posedge clk);
  endtask : pulse

  task automatic irq_is(input logic e);
    repeat (3) @(posedge clk);
    chk("cpu_irq", {31'h0, e}, {31'h0, cpu_irq});
  endtask : irq_is

  task automatic t_reset();
    logic [7:0] offs[6] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h18};
    foreach (offs[i]) rd(offs[i], 32'h0);
    chk("irqs", 32'h0, {30'h0, cpu_irq, evt_irq});
  endtask : t_reset

  task automatic t_regs();
    bus(1'b1, pir_pkg::OFF_EN4, 32'h0000_00FF);
    rd(pir_pkg::OFF_EN4, 32'h0000_0003);
    bus(1'b1, pir_pkg::OFF_EN4, 32'h0);
    // Byte lane off: acked, but the enables must stay clear
    sel <= 4'h0;
    bus(1'b1, pir_pkg::OFF_EN4, 32'h0000_0003);
    sel <= 4'h1;
    rd(pir_pkg::OFF_EN4, 32'h0);
    bus(1'b1, pir_pkg::OFF_REQ1, 32'h0000_00FF);
    rd(pir_pkg::OFF_REQ1, 32'h0000_00CF);
    @(posedge clk);
    chk("wb_dat_o idle", 32'h0, dat_o);
    chk("wb_ack_o idle", 32'h0, {31'h0, ack});
    bus(1'b1, pir_pkg::OFF_REQ1, 32'h0);
    rd(pir_pkg::OFF_REQ1, 32'h0);
    rd(8'h1C, 32'h0);
  endtask : t_regs

  task automatic t_events();
    uart <= 2'b11;
    pulse(5'b11111);
    rd(pir_pkg::OFF_REQ1, 32'h0000_00FD);
    rd(pir_pkg::OFF_EVT_STS, 32'h0000_00FD);
    uart <= 2'b00;
    repeat (3) @(posedge clk);
    rd(pir_pkg::OFF_REQ1, 32'h0000_00CD);
    bus(1'b1, pir_pkg::OFF_REQ1, 32'h0);
    @(posedge clk);
    t2_run <= 1'b1;
    repeat (12) @(posedge clk);
    t2_run <= 1'b0;
    rd(pir_pkg::OFF_REQ1, 32'h0000_0002);
    bus(1'b1, pir_pkg::OFF_REQ1, 32'h0);
  endtask : t_events

  task automatic t_irq();
    bus(1'b1, pir_pkg::OFF_EN1, 32'h0000_0001);
    pulse(5'b00001);
    irq_is(1'b0);
    bus(1'b1, pir_pkg::OFF_CORE, 32'h0000_0080);
    irq_is(1'b0);
    bus(1'b1, pir_pkg::OFF_CORE, 32'h0000_00C0);
    irq_is(1'b1);
    bus(1'b1, pir_pkg::OFF_REQ1, 32'h0);
    irq_is(1'b0);
    ser2 <= 2'b10;
    bus(1'b1, pir_pkg::OFF_EN4, 32'h0000_0002);
    irq_is(1'b1);
    bus(1'b1, pir_pkg::OFF_EN4, 32'h0000_0001);
    irq_is(1'b0);
    ser2 <= 2'b01;
    irq_is(1'b1);
    ser2 <= 2'b00;
    bus(1'b1, pir_pkg::OFF_EN4, 32'h0);
  endtask : t_irq

  task automatic t_evt();
    bus(1'b1, pir_pkg::OFF_EVT_CLR, 32'h0000_00FF);
    rd(pir_pkg::OFF_EVT_STS, 32'h0);
    bus(1'b1, pir_pkg::OFF_EVT_EN, 32'h0000_0040);
    pulse(5'b01000);
    chk("evt_irq", 32'h1, {31'h0, evt_irq});
    bus(1'b1, pir_pkg::OFF_EVT_CLR, 32'h0000_0040);
    repeat (3) @(posedge clk);
    chk("evt_irq", 32'h0, {31'h0, evt_irq});
    rd(pir_pkg::OFF_EVT_CLR, 32'h0);
  endtask : t_evt

  initial begin
    repeat (20000) @(posedge clk);
    errors++;
    $display("ERROR run expected done seen timeout");
    test_done();
  end

  initial begin
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    t_reset();
    t_regs();
    t_events();
    t_irq();
    t_evt();
    test_done();
  end
endmodule : pir_regs_tb
